// file: hdl/spm_port_control.sv
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - disabled speed stops all port operation
// - auto mode negotiates highest common speed
// - forced copper rates, 1G, serdes 2.5G
// - module speed from rom, copper auto
// - forced fibre rates disable copper side
// - dual media at 100-FX prefers fibre
// - dual media at 1000-X selectable preference
// - advertise selected duplex, all by default
// - advertise selected speeds, all by default
// - pause from config or negotiation result
// - report rx obey and tx send pause
// - 100FX reports flow control disabled
// - priority pause per priority, excludes pause
// - maximum frame size 1518 to 10240
// - discard frame after 16 collisions
// - restart backoff after 16 collisions
// - length field up to 1535, else type
// - check drops mismatched short frames
// - no mismatch drops unchecked, never counted
// - report link state and speed
module spm_port_control
	import spm_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire logic copperLinkPin,
	input wire logic fiberLinkPin,
	input wire logic anCompletePin,
	input wire logic [6:0] partnerAbilityPin,
	input wire logic [7:0] moduleRateCodePin,
	output logic portEnable,
	output logic copperEnable,
	output logic copperAnEnable,
	output logic [1:0] copperForceRate,
	output logic copperForceFdx,
	output logic fiberEnable,
	output logic [1:0] fiberRate,
	output logic fiberSelected,
	output logic [4:0] advAbility,
	output logic advPause,
	output logic linkUp,
	output logic [1:0] linkRate,
	output logic linkFdx,
	output logic rxPauseObey,
	output logic txPauseSend,
	output logic pfcEnable,
	output logic [7:0] pfcPrioMask,
	input wire logic txFrameStart,
	input wire logic txCollision,
	output logic txDiscard,
	output logic txBackoffRestart,
	input wire logic rxValid,
	input wire logic rxSof,
	input wire logic rxEof,
	input wire logic [7:0] rxData,
	output logic rxVerdictValid,
	output logic rxDrop,
	output logic rxTypeField
);
	// resolved rate and duplex of the best common ability, {valid, rate, fdx}
	function automatic logic [3:0] bestCommon(input logic [4:0] common);
		if (common[4]) begin
			bestCommon = {1'b1, SPM_RATE_1G, 1'b1};
		end else if (common[3]) begin
			bestCommon = {1'b1, SPM_RATE_100, 1'b1};
		end else if (common[2]) begin
			bestCommon = {1'b1, SPM_RATE_100, 1'b0};
		end else if (common[1]) begin
			bestCommon = {1'b1, SPM_RATE_10, 1'b1};
		end else begin
			bestCommon = {common[0], SPM_RATE_10, 1'b0};
		end
	endfunction

	// two-stage pin synchronisers
	logic [17:0] pinMeta_reg;
	logic [17:0] pinSync_reg;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pinMeta_reg <= 18'h0_0000;
			pinSync_reg <= 18'h0_0000;
		end else begin
			pinMeta_reg <= {copperLinkPin, fiberLinkPin, anCompletePin,
				partnerAbilityPin, moduleRateCodePin};
			pinSync_reg <= pinMeta_reg;
		end
	end
	wire copperUp = pinSync_reg[17];
	wire fiberUp = pinSync_reg[16];
	wire anComplete = pinSync_reg[15];
	wire [6:0] partnerAbility = pinSync_reg[14:8];
	wire [7:0] moduleRateCode = pinSync_reg[7:0];

	logic [31:0] ctrl_reg;
	logic [13:0] maxFrame_reg;
	logic [31:0] drops_reg;
	wire [3:0] speedMode = ctrl_reg[SPM_CTRL_SPEED_LSB +: 4];
	wire fcEnable = ctrl_reg[SPM_CTRL_FC_EN];

	// register port decode
	wire wrCtrl = regWr && (regAddr == SPM_ADDR_CTRL);
	wire wrMaxFrame = regWr && (regAddr == SPM_ADDR_MAXFRAME);
	wire wrDrops = regWr && (regAddr == SPM_ADDR_DROPS);
	// priority pause refused while pause is on
	wire [31:0] ctrlMasked = regWrData & SPM_CTRL_WMASK;
	wire [31:0] ctrlWrite = regWrData[SPM_CTRL_FC_EN] ?
		(ctrlMasked & ~(32'h0000_0001 << SPM_CTRL_PFC_EN)) : ctrlMasked;
	// maximum frame size kept inside its range
	wire [13:0] maxFrameWrite = (regWrData[31:14] != 18'h0_0000 ||
		regWrData[13:0] > SPM_MAXFRAME_MAX) ? SPM_MAXFRAME_MAX :
		(regWrData[13:0] < SPM_MAXFRAME_MIN) ? SPM_MAXFRAME_MIN : regWrData[13:0];

	// mode decode
	wire modeAuto = speedMode == SPM_SPD_AUTO;
	wire modeModuleAuto = speedMode == SPM_SPD_MODULE_AUTO;
	wire modeForcedCopper = (speedMode >= SPM_SPD_10_HALF) && (speedMode <= SPM_SPD_1G_FULL);
	wire mode2G5 = speedMode == SPM_SPD_2G5_FULL;
	wire mode100Fx = speedMode == SPM_SPD_100FX;
	wire mode1000X = speedMode == SPM_SPD_1000X;
	// disabled and unknown codes stop the port
	wire portOn = modeAuto || modeModuleAuto || modeForcedCopper || mode2G5 ||
		mode100Fx || mode1000X;

	// module speed from rom rate byte; zero means not detectable
	wire moduleKnown = moduleRateCode != 8'h00;
	wire [1:0] moduleRate = (moduleRateCode >= SPM_ROM_RATE_1G_MIN) ? SPM_RATE_1G : SPM_RATE_100;
	wire [1:0] fiberRateNext = mode2G5 ? SPM_RATE_2G5 : mode100Fx ? SPM_RATE_100 :
		mode1000X ? SPM_RATE_1G : moduleRate;
	// forced fibre rates leave copper off
	wire copperAllowed = modeAuto || modeForcedCopper || modeModuleAuto;
	wire fiberAllowed = mode2G5 || mode100Fx || mode1000X || (modeModuleAuto && moduleKnown);
	// fibre preferred at 100-FX; selectable at 1000-X
	wire fiberPreferred = !copperAllowed || (fiberRateNext == SPM_RATE_100) ||
		ctrl_reg[SPM_CTRL_FIBER_PREF];
	wire useFiber = fiberAllowed && (fiberUp ? (fiberPreferred || !copperUp) : !copperAllowed);
	wire mediaUp = useFiber ? fiberUp : copperUp;
	// copper in auto or module auto negotiates
	wire useAn = !useFiber && (modeAuto || modeModuleAuto);

	// duplex and speed advertisement, 1G is full duplex only
	wire advFdx = ctrl_reg[SPM_CTRL_ADV_FDX];
	wire advHdx = ctrl_reg[SPM_CTRL_ADV_HDX];
	wire [4:0] advNext = {ctrl_reg[SPM_CTRL_ADV_1G] && advFdx,
		ctrl_reg[SPM_CTRL_ADV_100] && advFdx, ctrl_reg[SPM_CTRL_ADV_100] && advHdx,
		ctrl_reg[SPM_CTRL_ADV_10] && advFdx, ctrl_reg[SPM_CTRL_ADV_10] && advHdx};
	wire [3:0] resolved = bestCommon(advNext & partnerAbility[4:0]);

	// forced rate and duplex of the copper side
	wire [1:0] forceRateNext = (speedMode >= SPM_SPD_1G_FULL) ? SPM_RATE_1G :
		(speedMode >= SPM_SPD_100_HALF) ? SPM_RATE_100 : SPM_RATE_10;
	wire forceFdxNext = (speedMode == SPM_SPD_10_FULL) || (speedMode == SPM_SPD_100_FULL) ||
		(speedMode == SPM_SPD_1G_FULL);

	spm_link_e linkState_reg;
	spm_link_e linkState_next;
	logic [1:0] anRate_reg;
	logic anFdx_reg;
	logic anRxPause_reg;
	logic anTxPause_reg;

	always_comb begin
		linkState_next = linkState_reg;
		case (linkState_reg)
			LINK_DOWN: begin
				if (portOn && mediaUp) begin
					linkState_next = useAn ? LINK_NEGOTIATE : LINK_UP;
				end
			end
			LINK_NEGOTIATE: begin
				if (!portOn || !mediaUp || !useAn) begin
					linkState_next = LINK_DOWN;
				end else if (anComplete && resolved[3]) begin
					linkState_next = LINK_UP;
				end
			end
			LINK_UP: begin
				if (!portOn || !mediaUp) begin
					linkState_next = LINK_DOWN;
				end
			end
			default: begin
				linkState_next = LINK_DOWN;
			end
		endcase
	end

	// pause per last negotiation, obey on partner bit 5 or 6, send on bit 5 only
	wire anRxPauseNext = fcEnable && (partnerAbility[5] || partnerAbility[6]);
	wire anTxPauseNext = fcEnable && partnerAbility[5];
	wire takeResult = (linkState_reg == LINK_NEGOTIATE) && (linkState_next == LINK_UP);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			linkState_reg <= LINK_DOWN;
			anRate_reg <= SPM_RATE_10;
			anFdx_reg <= 1'b0;
			anRxPause_reg <= 1'b0;
			anTxPause_reg <= 1'b0;
		end else begin
			linkState_reg <= linkState_next;
			if (takeResult) begin
				anRate_reg <= resolved[2:1];
				anFdx_reg <= resolved[0];
				anRxPause_reg <= anRxPauseNext;
				anTxPause_reg <= anTxPauseNext;
			end
		end
	end

	// result taken on this edge reaches the outputs together with linkUp
	wire [1:0] anRateNow = takeResult ? resolved[2:1] : anRate_reg;
	wire anFdxNow = takeResult ? resolved[0] : anFdx_reg;
	wire anRxNow = takeResult ? anRxPauseNext : anRxPause_reg;
	wire anTxNow = takeResult ? anTxPauseNext : anTxPause_reg;
	wire linkUpNext = linkState_next == LINK_UP;
	wire [1:0] linkRateNext = useFiber ? fiberRateNext : useAn ? anRateNow : forceRateNext;
	wire linkFdxNext = useFiber || (useAn ? anFdxNow : forceFdxNext);
	// no negotiation at 100FX, flow control shows disabled
	wire fiber100 = useFiber && (fiberRateNext == SPM_RATE_100);
	// fixed speed uses configured flow control
	wire rxPauseNext = portOn && !fiber100 && (useAn ? anRxNow : fcEnable);
	wire txPauseNext = portOn && !fiber100 && (useAn ? anTxNow : fcEnable);
	// priority pause never negotiated, never with pause
	wire pfcNext = portOn && ctrl_reg[SPM_CTRL_PFC_EN] && !fcEnable;

	// excessive collisions
	logic [4:0] collisions_reg;
	wire [4:0] collisionsInc = collisions_reg + 5'h01;
	wire collisionLimit = txCollision && (collisionsInc == SPM_COLLISION_LIMIT);
	wire restartMode = ctrl_reg[SPM_CTRL_EXC_RESTART];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			collisions_reg <= 5'h00;
			txDiscard <= 1'b0;
			txBackoffRestart <= 1'b0;
		end else begin
			if (txFrameStart || collisionLimit) begin
				collisions_reg <= 5'h00;
			end else if (txCollision) begin
				collisions_reg <= collisionsInc;
			end
			txDiscard <= (txFrameStart && !portOn) || (collisionLimit && !restartMode);
			txBackoffRestart <= collisionLimit && restartMode && portOn;
		end
	end

	logic oversizeDrop;
	spm_rx_len_check rxCheck (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.rxValid(rxValid),
		.rxSof(rxSof),
		.rxEof(rxEof),
		.rxData(rxData),
		.portOn(portOn),
		.lenCheckEn(ctrl_reg[SPM_CTRL_LEN_CHECK]),
		.maxFrameSize(maxFrame_reg),
		.verdictValid(rxVerdictValid),
		.frameDrop(rxDrop),
		.oversizeDrop(oversizeDrop),
		.typeField(rxTypeField)
	);

	// registers; a drop in the clearing cycle still counts
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= SPM_CTRL_RESET;
			maxFrame_reg <= SPM_MAXFRAME_RESET[13:0];
			drops_reg <= 32'h0000_0000;
		end else begin
			if (wrCtrl) begin
				ctrl_reg <= ctrlWrite;
			end
			if (wrMaxFrame) begin
				maxFrame_reg <= maxFrameWrite;
			end
			if (wrDrops) begin
				drops_reg <= {31'h0000_0000, oversizeDrop};
			end else if (oversizeDrop && drops_reg != 32'hFFFF_FFFF) begin
				drops_reg <= drops_reg + 32'h0000_0001;
			end
		end
	end

	logic [31:0] status;
	always_comb begin
		status = 32'h0000_0000;
		status[SPM_STAT_LINK_UP] = linkUp;
		status[SPM_STAT_RATE_LSB +: 2] = linkRate;
		status[SPM_STAT_FDX] = linkFdx;
		status[SPM_STAT_FIBER] = fiberSelected;
		status[SPM_STAT_RX_PAUSE] = rxPauseObey;
		status[SPM_STAT_TX_PAUSE] = txPauseSend;
		status[SPM_STAT_PFC] = pfcEnable;
		status[SPM_STAT_SFP_UNKNOWN] = modeModuleAuto && !moduleKnown;
		status[SPM_STAT_NEGOTIATING] = linkState_reg == LINK_NEGOTIATE;
	end

	wire [31:0] readMux = (regAddr == SPM_ADDR_CTRL) ? ctrl_reg :
		(regAddr == SPM_ADDR_MAXFRAME) ? {18'h0_0000, maxFrame_reg} :
		(regAddr == SPM_ADDR_STATUS) ? status :
		(regAddr == SPM_ADDR_DROPS) ? drops_reg : 32'h0000_0000;

	// port-facing outputs, all registered
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= 32'h0000_0000;
			portEnable <= 1'b0;
			copperEnable <= 1'b0;
			copperAnEnable <= 1'b0;
			copperForceRate <= SPM_RATE_10;
			copperForceFdx <= 1'b0;
			fiberEnable <= 1'b0;
			fiberRate <= SPM_RATE_10;
			fiberSelected <= 1'b0;
			advAbility <= 5'h00;
			advPause <= 1'b0;
			linkUp <= 1'b0;
			linkRate <= SPM_RATE_10;
			linkFdx <= 1'b0;
			rxPauseObey <= 1'b0;
			txPauseSend <= 1'b0;
			pfcEnable <= 1'b0;
			pfcPrioMask <= 8'h00;
		end else begin
			regRdData <= regRd ? readMux : 32'h0000_0000;
			portEnable <= portOn;
			copperEnable <= copperAllowed;
			copperAnEnable <= modeAuto || modeModuleAuto;
			copperForceRate <= forceRateNext;
			copperForceFdx <= forceFdxNext;
			fiberEnable <= fiberAllowed;
			fiberRate <= fiberRateNext;
			fiberSelected <= useFiber;
			advAbility <= advNext;
			advPause <= fcEnable;
			linkUp <= linkUpNext;
			linkRate <= linkRateNext;
			linkFdx <= linkFdxNext;
			rxPauseObey <= rxPauseNext;
			txPauseSend <= txPauseNext;
			pfcEnable <= pfcNext;
			pfcPrioMask <= pfcNext ? ctrl_reg[SPM_CTRL_PFC_PRIO_LSB +: 8] : 8'h00;
		end
	end
endmodule
`default_nettype wire

// file: shared/spm_pkg.sv
`default_nettype none
package spm_pkg;
	// register offsets on the plain register port
	localparam logic [7:0] SPM_ADDR_CTRL = 8'h00;
	localparam logic [7:0] SPM_ADDR_MAXFRAME = 8'h04;
	localparam logic [7:0] SPM_ADDR_STATUS = 8'h08;
	localparam logic [7:0] SPM_ADDR_DROPS = 8'h0C;

	// control register fields
	localparam int SPM_CTRL_SPEED_LSB = 0;
	localparam int SPM_CTRL_ADV_FDX = 4;
	localparam int SPM_CTRL_ADV_HDX = 5;
	localparam int SPM_CTRL_ADV_10 = 6;
	localparam int SPM_CTRL_ADV_100 = 7;
	localparam int SPM_CTRL_ADV_1G = 8;
	localparam int SPM_CTRL_FC_EN = 9;
	localparam int SPM_CTRL_PFC_EN = 10;
	localparam int SPM_CTRL_EXC_RESTART = 11;
	localparam int SPM_CTRL_LEN_CHECK = 12;
	localparam int SPM_CTRL_FIBER_PREF = 13;
	localparam int SPM_CTRL_PFC_PRIO_LSB = 16;
	localparam logic [31:0] SPM_CTRL_RESET = 32'h0000_01F1;
	localparam logic [31:0] SPM_CTRL_WMASK = 32'h00FF_3FFF;

	// status register fields
	localparam int SPM_STAT_LINK_UP = 0;
	localparam int SPM_STAT_RATE_LSB = 1;
	localparam int SPM_STAT_FDX = 3;
	localparam int SPM_STAT_FIBER = 4;
	localparam int SPM_STAT_RX_PAUSE = 5;
	localparam int SPM_STAT_TX_PAUSE = 6;
	localparam int SPM_STAT_PFC = 7;
	localparam int SPM_STAT_SFP_UNKNOWN = 8;
	localparam int SPM_STAT_NEGOTIATING = 9;

	// configured link speed codes
	localparam logic [3:0] SPM_SPD_DISABLED = 4'h0;
	localparam logic [3:0] SPM_SPD_AUTO = 4'h1;
	localparam logic [3:0] SPM_SPD_10_HALF = 4'h2;
	localparam logic [3:0] SPM_SPD_10_FULL = 4'h3;
	localparam logic [3:0] SPM_SPD_100_HALF = 4'h4;
	localparam logic [3:0] SPM_SPD_100_FULL = 4'h5;
	localparam logic [3:0] SPM_SPD_1G_FULL = 4'h6;
	localparam logic [3:0] SPM_SPD_2G5_FULL = 4'h7;
	localparam logic [3:0] SPM_SPD_MODULE_AUTO = 4'h8;
	localparam logic [3:0] SPM_SPD_100FX = 4'h9;
	localparam logic [3:0] SPM_SPD_1000X = 4'hA;

	// operating rate codes
	localparam logic [1:0] SPM_RATE_10 = 2'h0;
	localparam logic [1:0] SPM_RATE_100 = 2'h1;
	localparam logic [1:0] SPM_RATE_1G = 2'h2;
	localparam logic [1:0] SPM_RATE_2G5 = 2'h3;

	// module rom nominal rate byte, units of 100 MBd
	localparam logic [7:0] SPM_ROM_RATE_1G_MIN = 8'h0A;

	// frame size limits and layout
	localparam logic [13:0] SPM_MAXFRAME_MIN = 14'h05EE;
	localparam logic [13:0] SPM_MAXFRAME_MAX = 14'h2800;
	localparam logic [31:0] SPM_MAXFRAME_RESET = 32'h0000_05EE;
	localparam logic [15:0] SPM_LEN_FIELD_MAX = 16'h05FF;
	localparam logic [14:0] SPM_LEN_CHECK_LIMIT = 15'h0600;
	localparam logic [14:0] SPM_HEADER_BYTES = 15'h000E;
	localparam logic [14:0] SPM_FCS_BYTES = 15'h0004;
	localparam logic [14:0] SPM_MIN_PAYLOAD = 15'h002E;
	localparam logic [13:0] SPM_LEN_HI_POS = 14'h000C;
	localparam logic [13:0] SPM_LEN_LO_POS = 14'h000D;

	// excessive collision limit
	localparam logic [4:0] SPM_COLLISION_LIMIT = 5'h10;

	typedef enum logic [1:0] {
		LINK_DOWN,
		LINK_NEGOTIATE,
		LINK_UP
	} spm_link_e;
endpackage
`default_nettype wire

// file: hdl/spm_rx_len_check.sv
`timescale 1ns/1ps
`default_nettype none
module spm_rx_len_check
	import spm_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic rxValid,
	input wire logic rxSof,
	input wire logic rxEof,
	input wire logic [7:0] rxData,
	input wire logic portOn,
	input wire logic lenCheckEn,
	input wire logic [13:0] maxFrameSize,
	output logic verdictValid,
	output logic frameDrop,
	output logic oversizeDrop,
	output logic typeField
);
	logic [13:0] byteCount_reg;
	logic [7:0] lenHi_reg;
	logic [7:0] lenLo_reg;

	wire [13:0] bytePos = rxSof ? 14'h0000 : byteCount_reg;
	wire [14:0] frameLen = {1'b0, bytePos} + 15'h0001;
	wire [14:0] overhead = SPM_HEADER_BYTES + SPM_FCS_BYTES;
	wire [14:0] payloadLen = (frameLen > overhead) ? frameLen - overhead : 15'h0000;
	wire [15:0] lenField = {lenHi_reg, lenLo_reg};
	wire isLength = lenField <= SPM_LEN_FIELD_MAX;
	// short frames carry pad bytes, so a small length field is legal at minimum payload
	wire padded = (payloadLen == SPM_MIN_PAYLOAD) && (lenField < {1'b0, SPM_MIN_PAYLOAD});
	wire mismatch = isLength && (payloadLen < SPM_LEN_CHECK_LIMIT) &&
		(lenField != {1'b0, payloadLen}) && !padded;
	wire oversize = frameLen > {1'b0, maxFrameSize};
	wire frameEnd = rxValid && rxEof;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			byteCount_reg <= 14'h0000;
			lenHi_reg <= 8'h00;
			lenLo_reg <= 8'h00;
		end else if (rxValid) begin
			byteCount_reg <= (bytePos == 14'h3FFF) ? bytePos : bytePos + 14'h0001;
			if (bytePos == SPM_LEN_HI_POS) begin
				lenHi_reg <= rxData;
			end
			if (bytePos == SPM_LEN_LO_POS) begin
				lenLo_reg <= rxData;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			verdictValid <= 1'b0;
			frameDrop <= 1'b0;
			oversizeDrop <= 1'b0;
			typeField <= 1'b0;
		end else begin
			verdictValid <= frameEnd;
			// length mismatch drop only when check on; oversize or port off drop always
			frameDrop <= frameEnd && (!portOn || oversize || (lenCheckEn && mismatch));
			oversizeDrop <= frameEnd && portOn && oversize;
			if (frameEnd) begin
				typeField <= !isLength;
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench/spm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spm_chk
	import spm_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic portEnable,
	input wire logic linkUp,
	input wire logic [1:0] linkRate,
	input wire logic fiberSelected,
	input wire logic rxPauseObey,
	input wire logic txPauseSend,
	input wire logic pfcEnable,
	input wire logic [7:0] pfcPrioMask,
	input wire logic txFrameStart,
	input wire logic txCollision,
	input wire logic txDiscard,
	input wire logic txBackoffRestart,
	input wire logic rxValid,
	input wire logic rxEof,
	input wire logic rxVerdictValid,
	input wire logic rxDrop
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// collisions since frame start, modulo the limit
	logic [4:0] colCnt;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) colCnt <= 5'h00;
		else if (txFrameStart) colCnt <= 5'h00;
		else if (txCollision) colCnt <= (colCnt == 5'd15) ? 5'h00 : colCnt + 5'd1;
	end
	a_off_tx_discard: assert property (txFrameStart && !portEnable |=> txDiscard)
		else $error("frame start on a disabled port not discarded");
	a_off_rx_drop: assert property (rxValid && rxEof && !portEnable |=> rxDrop && rxVerdictValid)
		else $error("frame on a disabled port not dropped");
	a_off_no_link: assert property (!portEnable [*3] |-> !linkUp)
		else $error("link up on a disabled port");
	a_exc_collision: assert property (txCollision && !txFrameStart && colCnt == 5'd15
		|=> txDiscard != txBackoffRestart)
		else $error("no single action after the sixteenth collision");
	a_restart_cause: assert property (txBackoffRestart |-> $past(txCollision) && $past(colCnt) == 5'd15)
		else $error("backoff restart without sixteen collisions");
	a_verdict_cause: assert property (rxVerdictValid |-> $past(rxValid && rxEof))
		else $error("verdict without an end of frame");
	a_fx_no_pause: assert property (linkUp && fiberSelected && linkRate == SPM_RATE_100
		|-> !rxPauseObey && !txPauseSend)
		else $error("pause active on a fibre link at 100");
	a_pause_pair: assert property (txPauseSend |-> rxPauseObey)
		else $error("pause sent but not obeyed");
	a_pfc_mask: assert property (!pfcEnable |-> pfcPrioMask == 8'h00)
		else $error("priority mask set while priority pause off");
endmodule
bind spm_port_control spm_chk chk (.*);
`default_nettype wire

// file: testbench/spm_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module spm_link_partner (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic copperOn,
	input wire logic fiberOn,
	input wire logic anEnable,
	input wire logic [6:0] ability,
	input wire logic [7:0] rateCode,
	output logic copperLinkPin,
	output logic fiberLinkPin,
	output logic anCompletePin,
	output logic [6:0] partnerAbilityPin,
	output logic [7:0] moduleRateCodePin
);
	// negotiation takes a few cycles and only while our side negotiates
	logic [3:0] anCnt;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			anCnt <= 4'h0;
			anCompletePin <= 1'b0;
		end else begin
			anCnt <= (copperOn && anEnable) ? ((anCnt == 4'd6) ? anCnt : anCnt + 4'd1) : 4'h0;
			anCompletePin <= anCnt == 4'd6;
		end
	end
	assign copperLinkPin = copperOn;
	assign fiberLinkPin = fiberOn;
	assign partnerAbilityPin = ability;
	assign moduleRateCodePin = rateCode;
endmodule
`default_nettype wire

// file: testbench/test_switch_port_mac_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_switch_port_mac_control;
	import spm_pkg::*;
	localparam logic [31:0] FC = 32'h0000_0200;
	localparam logic [31:0] ADVALL = 32'h0000_01F0;
	logic core_clk = 0, arst_n = 0, regWr = 0, regRd = 0, pCu = 0, pFi = 0;
	logic txFrameStart = 0, txCollision = 0, rxValid = 0, rxSof = 0, rxEof = 0;
	logic [7:0] regAddr = 8'h00, rxData = 8'h00, pRate = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000, regRdData, rd;
	logic [6:0] pAb = 7'h7F, partnerAbilityPin;
	logic copperLinkPin, fiberLinkPin, anCompletePin, portEnable, copperEnable, copperAnEnable;
	logic copperForceFdx, fiberEnable, fiberSelected, advPause, linkUp, linkFdx, drp;
	logic [7:0] moduleRateCodePin, pfcPrioMask;
	logic [1:0] copperForceRate, fiberRate, linkRate;
	logic [4:0] advAbility;
	logic rxPauseObey, txPauseSend, pfcEnable, txDiscard, txBackoffRestart;
	logic rxVerdictValid, rxDrop, rxTypeField;
	int failures = 0, samples_checked = 0, cycles = 0;
	spm_port_control uut (.*);
	spm_link_partner partner (.copperOn(pCu), .fiberOn(pFi), .anEnable(copperAnEnable),
		.ability(pAb), .rateCode(pRate), .*);
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regWr <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 0;
	endtask
	task automatic rdv(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regRd <= 1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 0;
		#1 d = regRdData;
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_link();
		int i;
		// let a mode or pin change ripple through the synchronisers first
		waitc(3);
		for (i = 0; i < 100 && linkUp !== 1'b1; i++) @(posedge core_clk);
		#1 chk("linkUp", 1, linkUp);
	endtask
	task automatic send_frame(input int len, input logic [15:0] fld, output logic dr);
		for (int i = 0; i < len; i++) begin
			@(posedge core_clk);
			rxValid <= 1;
			rxSof <= i == 0;
			rxEof <= i == len - 1;
			rxData <= (i == 12) ? fld[15:8] : (i == 13) ? fld[7:0] : 8'(i);
		end
		@(posedge core_clk);
		rxValid <= 0;
		rxEof <= 0;
		#1 chk("rxVerdictValid", 1, rxVerdictValid);
		dr = rxDrop;
	endtask
	task automatic t_reset();
		rdv(SPM_ADDR_CTRL, rd); chk("ctrl", SPM_CTRL_RESET, rd);
		rdv(SPM_ADDR_MAXFRAME, rd); chk("maxframe", SPM_MAXFRAME_RESET, rd);
		rdv(8'h10, rd); chk("unmapped", 0, rd);
		chk("advAbility", 5'h1F, advAbility);
	endtask
	task automatic t_advertise();
		wr(SPM_ADDR_CTRL, SPM_SPD_AUTO | 32'h0000_0090 | FC);
		waitc(2); chk("advAbility", 5'h08, advAbility);
		chk("advPause", 1, advPause);
		wr(SPM_ADDR_CTRL, SPM_SPD_AUTO | 32'h0000_0160);
		waitc(2); chk("advAbility", 5'h01, advAbility);
		pAb <= 7'h10;
		pCu <= 1;
		waitc(60); chk("no common link", 0, linkUp);
		pCu <= 0;
	endtask
	task automatic t_autoneg();
		pAb <= 7'h4F;
		wr(SPM_ADDR_CTRL, SPM_SPD_AUTO | ADVALL | FC);
		pCu <= 1;
		wait_link();
		chk("linkRate", SPM_RATE_100, linkRate);
		chk("linkFdx", 1, linkFdx);
		chk("rx obey tx send", 2'b10, {rxPauseObey, txPauseSend});
		rdv(SPM_ADDR_STATUS, rd); chk("status", 8'h2B, rd & 32'h0000_00FF);
		pCu <= 0;
		pAb <= 7'h7F;
	endtask
	task automatic t_forced();
		logic [3:0] code [5] = '{SPM_SPD_10_HALF, SPM_SPD_10_FULL, SPM_SPD_100_HALF,
			SPM_SPD_100_FULL, SPM_SPD_1G_FULL};
		logic [1:0] rate [5] = '{SPM_RATE_10, SPM_RATE_10, SPM_RATE_100, SPM_RATE_100, SPM_RATE_1G};
		logic fdx [5] = '{0, 1, 0, 1, 1};
		for (int i = 0; i < 5; i++) begin
			pCu <= 0;
			wr(SPM_ADDR_CTRL, code[i] | FC);
			waitc(4);
			pCu <= 1;
			wait_link();
			chk("copperAnEnable", 0, copperAnEnable);
			chk("copperForceRate", rate[i], copperForceRate);
			chk("linkRate", rate[i], linkRate);
			chk("linkFdx", fdx[i], linkFdx);
			chk("pause forced", 2'b11, {rxPauseObey, txPauseSend});
		end
		pCu <= 0;
	endtask
	task automatic t_fiber();
		wr(SPM_ADDR_CTRL, SPM_SPD_100FX | FC);
		pCu <= 1;
		pFi <= 1;
		wait_link();
		chk("copperEnable", 0, copperEnable);
		chk("fiberSelected", 1, fiberSelected);
		chk("fx pause", 2'b00, {rxPauseObey, txPauseSend});
		pRate <= 8'h00;
		wr(SPM_ADDR_CTRL, SPM_SPD_MODULE_AUTO | ADVALL);
		waitc(6); chk("fiberEnable", 0, fiberEnable);
		chk("copperAnEnable", 1, copperAnEnable);
		pRate <= 8'h0C;
		wr(SPM_ADDR_CTRL, SPM_SPD_MODULE_AUTO | ADVALL | 32'h0000_2000);
		waitc(8); chk("fiberRate", SPM_RATE_1G, fiberRate);
		chk("fibre preferred", 1, fiberSelected);
		wr(SPM_ADDR_CTRL, SPM_SPD_MODULE_AUTO | ADVALL);
		waitc(8); chk("copper preferred", 0, fiberSelected);
		pCu <= 0;
		pFi <= 0;
	endtask
	task automatic t_pfc();
		wr(SPM_ADDR_CTRL, SPM_SPD_AUTO | FC | 32'h0089_0400);
		rdv(SPM_ADDR_CTRL, rd); chk("pfc refused", 0, rd[10]);
		chk("pfcEnable", 0, pfcEnable);
		wr(SPM_ADDR_CTRL, SPM_SPD_AUTO | 32'h0089_0400);
		waitc(2); chk("pfcPrioMask", 8'h89, pfcPrioMask);
		chk("pfcEnable", 1, pfcEnable);
	endtask
	task automatic t_collide(input logic restart);
		wr(SPM_ADDR_CTRL, SPM_SPD_AUTO | ADVALL | (32'(restart) << 11));
		@(posedge core_clk);
		txFrameStart <= 1;
		for (int i = 0; i < 16; i++) begin
			@(posedge core_clk);
			txFrameStart <= 0;
			txCollision <= 1;
			#1 if (i == 15) chk("early action", 0, txDiscard | txBackoffRestart);
		end
		@(posedge core_clk);
		txCollision <= 0;
		#1 chk("discard restart", {!restart, restart}, {txDiscard, txBackoffRestart});
	endtask
	task automatic t_rx();
		wr(SPM_ADDR_CTRL, SPM_SPD_AUTO | ADVALL);
		send_frame(64, 16'h002E, drp); chk("len ok drop", 0, drp);
		chk("rxTypeField", 0, rxTypeField);
		send_frame(64, 16'h0800, drp); chk("rxTypeField", 1, rxTypeField);
		send_frame(100, 16'h0032, drp); chk("unchecked drop", 0, drp);
		wr(SPM_ADDR_CTRL, SPM_SPD_AUTO | ADVALL | 32'h0000_1000);
		send_frame(100, 16'h0032, drp); chk("mismatch drop", 1, drp);
		send_frame(100, 16'h0052, drp); chk("match drop", 0, drp);
		wr(SPM_ADDR_MAXFRAME, 32'h0000_0064);
		rdv(SPM_ADDR_MAXFRAME, rd); chk("max clamp low", 32'h0000_05EE, rd);
		send_frame(1519, 16'h0800, drp); chk("oversize drop", 1, drp);
		send_frame(1518, 16'h0800, drp); chk("max size drop", 0, drp);
		rdv(SPM_ADDR_DROPS, rd); chk("drops", 1, rd);
		wr(SPM_ADDR_MAXFRAME, 32'h0000_3000);
		rdv(SPM_ADDR_MAXFRAME, rd); chk("max clamp high", 32'h0000_2800, rd);
		wr(SPM_ADDR_CTRL, 32'h0000_0000);
		waitc(2); chk("portEnable", 0, portEnable);
		send_frame(64, 16'h0800, drp); chk("disabled drop", 1, drp);
		@(posedge core_clk);
		txFrameStart <= 1;
		@(posedge core_clk);
		txFrameStart <= 0;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		arst_n <= 1;
		t_reset();
		t_advertise();
		t_autoneg();
		t_forced();
		t_fiber();
		t_pfc();
		t_collide(0);
		t_collide(1);
		t_rx();
		waitc(4);
		close_out();
	end
endmodule
`default_nettype wire
